//--- core/aes_cfg.svh
// Timing constants and limits for the alternator excitation sequencer.
`ifndef AES_CFG_SVH
`define AES_CFG_SVH
`define AES_CLK_HZ 40000000
`define AES_TICK_HZ 1000
`define AES_TICK_DIV (`AES_CLK_HZ / `AES_TICK_HZ)
`define AES_DELAY_MS 4000
`define AES_ON_MS 500
`define AES_OFF_MS 500
`define AES_LP_DELAY_MS 1000
`define AES_MAX_PULSES 60
`define AES_DEB_TICKS 4
`endif

//--- core/aes_pkg.sv
// Types shared by the alternator excitation sequencer.
`default_nettype none
package aes_pkg;
	typedef enum logic [3:0] {
		AES_SLEEP, AES_WAIT_REL, AES_DELAY, AES_ON, AES_OFF, AES_WAIT_RISE,
		AES_DIODE, AES_REX_ON, AES_REX_OFF
	} aes_state_t;
	typedef struct packed {
		logic starter;
		logic ignition;
		logic rex_trig;
		logic anode_gt_cath;
		logic charging;
		logic override;
	} aes_in_t;
endpackage
`default_nettype wire

//--- core/aes_seq.sv
// Alternator excitation sequencer driving the rectifier switch array.
`include "aes_cfg.svh"
`default_nettype none
module aes_seq import aes_pkg::*; #(
	parameter int TICK_DIV = `AES_TICK_DIV,
	parameter int DELAY_TICKS = `AES_DELAY_MS,
	parameter int ON_TICKS = `AES_ON_MS,
	parameter int OFF_TICKS = `AES_OFF_MS,
	parameter int LP_TICKS = `AES_LP_DELAY_MS,
	parameter int MAX_PULSES = `AES_MAX_PULSES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire aes_in_t pins,
	output logic array_on,
	output logic low_power,
	output logic diode_mode,
	output logic excit_active
);
	localparam int W = $bits(aes_in_t);
	localparam logic [2:0] DEB_MAX = 3'(`AES_DEB_TICKS - 1);

	logic rst_s1_r, rst_n_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// Prescaler producing a one-cycle tick.
	logic [31:0] pre_r, pre_nxt;
	logic tick_r, tick_nxt;
	always_comb begin
		tick_nxt = 1'b0;
		pre_nxt = pre_r + 32'h1;
		if (pre_r >= 32'(TICK_DIV - 1)) begin
			pre_nxt = 32'h0;
			tick_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pre_r <= 32'h0;
			tick_r <= 1'b0;
		end else if (clk_en) begin
			pre_r <= pre_nxt;
			tick_r <= tick_nxt;
		end
	end

	// Two-stage synchronisers and tick-rate debouncers, one per input.
	aes_in_t s1_r, s2_r, deb_r;
	aes_in_t deb_nxt;
	logic [W-1:0][2:0] dcnt_r, dcnt_nxt;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_deb
			always_comb begin
				deb_nxt[g] = deb_r[g];
				dcnt_nxt[g] = dcnt_r[g];
				if (s2_r[g] == deb_r[g]) begin
					dcnt_nxt[g] = 3'h0;
				end else if (tick_r) begin
					if (dcnt_r[g] == DEB_MAX) begin
						deb_nxt[g] = s2_r[g];
						dcnt_nxt[g] = 3'h0;
					end else begin
						dcnt_nxt[g] = dcnt_r[g] + 3'h1;
					end
				end
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s1_r <= '0;
			s2_r <= '0;
			deb_r <= '0;
			dcnt_r <= '0;
		end else if (clk_en) begin
			s1_r <= pins;
			s2_r <= s1_r;
			deb_r <= deb_nxt;
			dcnt_r <= dcnt_nxt;
		end
	end

	aes_state_t st_r, st_nxt;
	logic [15:0] tmr_r, tmr_nxt;
	logic [6:0] pcnt_r, pcnt_nxt;
	logic ign_mode_r, ign_mode_nxt;
	logic strt_d_r, ign_d_r;
	logic array_r, array_nxt, lp_r, lp_nxt;
	logic strt_rise, ign_rise, ign_fall;
	assign strt_rise = deb_r.starter && !strt_d_r;
	assign ign_rise = deb_r.ignition && !ign_d_r;
	assign ign_fall = !deb_r.ignition && ign_d_r;

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		pcnt_nxt = pcnt_r;
		ign_mode_nxt = ign_mode_r;
		if (tick_r && tmr_r != 16'h0) begin
			tmr_nxt = tmr_r - 16'h1;
		end
		case (st_r)
			AES_SLEEP, AES_WAIT_RISE: begin
				if (strt_rise) begin
					st_nxt = AES_WAIT_REL;
					ign_mode_nxt = 1'b0;
				end else if (ign_rise) begin
					st_nxt = AES_DELAY;
					tmr_nxt = 16'(DELAY_TICKS);
					ign_mode_nxt = 1'b1;
				end
			end
			AES_WAIT_REL: begin
				if (!deb_r.starter) begin
					st_nxt = AES_DELAY;
					tmr_nxt = 16'(DELAY_TICKS);
				end
			end
			AES_DELAY: begin
				if (tick_r && tmr_r <= 16'h1) begin
					st_nxt = AES_ON;
					tmr_nxt = 16'(ON_TICKS);
					pcnt_nxt = 7'h1;
				end
			end
			AES_ON: begin
				if (deb_r.charging) begin
					st_nxt = AES_DIODE;
				end else if (tick_r && tmr_r <= 16'h1) begin
					st_nxt = AES_OFF;
					tmr_nxt = 16'(OFF_TICKS);
				end
			end
			AES_OFF: begin
				if (tick_r && tmr_r <= 16'h1) begin
					if (pcnt_r >= 7'(MAX_PULSES)) begin
						st_nxt = AES_WAIT_RISE;
					end else begin
						st_nxt = AES_ON;
						tmr_nxt = 16'(ON_TICKS);
						pcnt_nxt = pcnt_r + 7'h1;
					end
				end
			end
			AES_DIODE: begin
				if (!deb_r.anode_gt_cath) begin
					if (deb_r.rex_trig) begin
						st_nxt = AES_REX_ON;
						tmr_nxt = 16'(ON_TICKS);
					end else if (tick_r && tmr_r <= 16'h1) begin
						st_nxt = AES_SLEEP;
					end
				end else begin
					tmr_nxt = 16'(LP_TICKS);
				end
			end
			AES_REX_ON: begin
				if (deb_r.charging) begin
					st_nxt = AES_DIODE;
					tmr_nxt = 16'(LP_TICKS);
				end else if (!deb_r.rex_trig) begin
					st_nxt = AES_DIODE;
					tmr_nxt = 16'(LP_TICKS);
				end else if (tick_r && tmr_r <= 16'h1) begin
					st_nxt = AES_REX_OFF;
					tmr_nxt = 16'(OFF_TICKS);
				end
			end
			AES_REX_OFF: begin
				if (!deb_r.rex_trig) begin
					st_nxt = AES_DIODE;
					tmr_nxt = 16'(LP_TICKS);
				end else if (tick_r && tmr_r <= 16'h1) begin
					st_nxt = AES_REX_ON;
					tmr_nxt = 16'(ON_TICKS);
				end
			end
			default: st_nxt = AES_SLEEP;
		endcase
		if (st_r == AES_DELAY || st_r == AES_ON || st_r == AES_OFF) begin
			if (strt_rise) begin
				st_nxt = AES_WAIT_REL;
				ign_mode_nxt = 1'b0;
			end else if (ign_mode_r && ign_fall) begin
				st_nxt = AES_WAIT_RISE;
			end
		end
	end

	always_comb begin
		array_nxt = st_nxt == AES_ON || st_nxt == AES_REX_ON;
		if (st_nxt == AES_DIODE && deb_r.anode_gt_cath) begin
			array_nxt = 1'b1;
		end
		if (deb_r.override) begin
			array_nxt = 1'b1;
		end
		lp_nxt = (st_nxt == AES_SLEEP || st_nxt == AES_WAIT_RISE) &&
			!deb_r.anode_gt_cath && !deb_r.override;
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= AES_SLEEP;
			tmr_r <= 16'h0;
			pcnt_r <= 7'h0;
			ign_mode_r <= 1'b0;
			strt_d_r <= 1'b0;
			ign_d_r <= 1'b0;
			array_r <= 1'b0;
			lp_r <= 1'b1;
			diode_mode <= 1'b0;
			excit_active <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			pcnt_r <= pcnt_nxt;
			ign_mode_r <= ign_mode_nxt;
			strt_d_r <= deb_r.starter;
			ign_d_r <= deb_r.ignition;
			array_r <= array_nxt;
			lp_r <= lp_nxt;
			diode_mode <= st_nxt == AES_DIODE;
			excit_active <= st_nxt inside {AES_DELAY, AES_ON, AES_OFF, AES_REX_ON, AES_REX_OFF};
		end
	end
	assign array_on = array_r;
	assign low_power = lp_r;

	a_override_on: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && deb_r.override |=> array_on) else $error("override not on");
	a_diode_off: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && st_r == AES_DIODE && !deb_r.anode_gt_cath && !deb_r.override &&
		!deb_r.rex_trig |=> !array_on) else $error("diode not off");
	a_pulse_cap: assert property (@(posedge clk) disable iff (!rst_n_r)
		st_r == AES_ON |-> pcnt_r <= 7'(MAX_PULSES)) else $error("pulse cap");
	a_charge_exit: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && st_r == AES_ON && deb_r.charging && !strt_rise && !(ign_mode_r && ign_fall)
		|=> st_r == AES_DIODE) else $error("no exit");
	a_abort_start: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && st_r inside {AES_ON, AES_OFF} && strt_rise && !deb_r.override
		|=> st_r == AES_WAIT_REL && !array_on) else $error("no abort");
	a_ign_drop: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && ign_mode_r && ign_fall && !strt_rise && st_r inside {AES_DELAY, AES_ON, AES_OFF}
		|=> st_r == AES_WAIT_RISE) else $error("ign drop");
	a_rex_start: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && st_r == AES_DIODE && !deb_r.anode_gt_cath && deb_r.rex_trig
		|=> st_r == AES_REX_ON ##0 array_on) else $error("no rex");
	a_wait_release: assert property (@(posedge clk) disable iff (!rst_n_r)
		clk_en && st_r == AES_WAIT_REL && deb_r.starter |=> st_r == AES_WAIT_REL)
		else $error("left early");
	a_lowpower: assert property (@(posedge clk) disable iff (!rst_n_r)
		low_power |-> !array_on) else $error("lp with array");
endmodule
`default_nettype wire

//--- verif/aes_vehicle.sv
// Vehicle-side model: trigger lines and an alternator that runs once excited.
`default_nettype none
module aes_vehicle import aes_pkg::*; (
	input wire logic clk,
	input wire logic array_on,
	input wire logic start_req,
	input wire logic ign_req,
	input wire logic rex_req,
	input wire logic alt_run,
	input wire logic ovr_req,
	output var aes_in_t pins
);
	timeunit 1ns;
	timeprecision 100ps;
	logic alt_prod_r;
	// The alternator only starts once battery voltage reaches it, then keeps running while alt_run stays high.
	always_ff @(posedge clk) begin
		alt_prod_r <= alt_run && (alt_prod_r || array_on);
	end
	always_comb begin
		pins = '{start_req, ign_req, rex_req, alt_prod_r, alt_prod_r, ovr_req};
	end
endmodule
`default_nettype wire

//--- verif/aes_seq_bench.sv
// Self-checking bench for the alternator excitation sequencer.
`include "aes_cfg.svh"
`default_nettype none
module aes_seq_bench import aes_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, st, ig, rx, run, ovr, ce;
	logic array_on, low_power, diode_mode, excit_active;
	aes_in_t pins;
	int num_errors, n_checks, np, hi;
	aes_vehicle u_veh (.clk(clk), .array_on(array_on), .start_req(st), .ign_req(ig),
		.rex_req(rx), .alt_run(run), .ovr_req(ovr), .pins(pins));
	aes_seq #(.TICK_DIV(4), .DELAY_TICKS(8), .ON_TICKS(4), .OFF_TICKS(4),
		.MAX_PULSES(3)) u_dut (.clk(clk), .reset_n(reset_n), .clk_en(ce), .pins(pins),
		.array_on(array_on), .low_power(low_power), .diode_mode(diode_mode),
		.excit_active(excit_active));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task chk(input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// Counts pulses and on-cycles of the array over a window.
	task pulses(input int lim);
		logic prev;
		prev = array_on;
		np = 0;
		hi = 0;
		repeat (lim) begin
			cyc(1);
			if (array_on && !prev) np++;
			if (array_on) hi++;
			prev = array_on;
		end
	endtask
	task t_starter;
		st = 1'b1;
		cyc(40);
		chk(low_power, 1'b0);
		chk(excit_active, 1'b0);
		st = 1'b0;
		cyc(30);
		chk(excit_active, 1'b1);
		chk(array_on, 1'b0);
		pulses(300);
		chk(np == 3, 1'b1);
		chk(hi >= 44 && hi <= 48, 1'b1);
		chk(excit_active, 1'b0);
		chk(low_power, 1'b1);
		$display("starter test done");
	endtask
	task t_abort;
		st = 1'b1;
		cyc(30);
		st = 1'b0;
		cyc(75);
		st = 1'b1;
		cyc(30);
		chk(excit_active, 1'b0);
		chk(array_on, 1'b0);
		st = 1'b0;
		cyc(30);
		chk(excit_active, 1'b1);
		pulses(300);
		chk(np == 3, 1'b1);
		chk(excit_active, 1'b0);
		$display("abort test done");
	endtask
	task t_rex;
		run = 1'b1;
		st = 1'b1;
		cyc(30);
		st = 1'b0;
		pulses(200);
		chk(diode_mode, 1'b1);
		chk(array_on, 1'b1);
		rx = 1'b1;
		run = 1'b0;
		pulses(250);
		chk(np > 3, 1'b1);
		chk(excit_active, 1'b1);
		run = 1'b1;
		pulses(80);
		chk(diode_mode, 1'b1);
		rx = 1'b0;
		run = 1'b0;
		cyc(25);
		chk(array_on, 1'b0);
		// The low-power delay runs at its default tick count, four cycles a tick here.
		cyc(4 * `AES_LP_DELAY_MS - 100);
		chk(low_power, 1'b0);
		cyc(200);
		chk(low_power, 1'b1);
		$display("re-excitation test done");
	endtask
	task t_ign_ovr;
		ig = 1'b1;
		pulses(100);
		chk(np >= 2, 1'b1);
		chk(excit_active, 1'b1);
		ig = 1'b0;
		cyc(30);
		chk(excit_active, 1'b0);
		chk(array_on, 1'b0);
		ovr = 1'b1;
		cyc(25);
		chk(array_on, 1'b1);
		chk(low_power, 1'b0);
		// With the clock enable low the released override must not be seen.
		ce = 1'b0;
		ovr = 1'b0;
		cyc(40);
		chk(array_on, 1'b1);
		ce = 1'b1;
		cyc(25);
		chk(array_on, 1'b0);
		chk(low_power, 1'b1);
		$display("ignition and override test done");
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		{st, ig, rx, run, ovr} = 5'h00;
		ce = 1'b1;
		num_errors = 0;
		n_checks = 0;
		reset_n = 1'b0;
		cyc(3);
		reset_n = 1'b1;
		cyc(10);
		chk(low_power, 1'b1);
		t_starter();
		t_abort();
		t_rex();
		t_ign_ovr();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule
`default_nettype wire
